//--- logic/hsc_pkg.sv
package hsc_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned MS_IN_NS      = 1000000;
    localparam int unsigned CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned S_PER_MIN     = 60;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_ACCEL     = 14'h21ec;
    localparam logic [13:0] IDX_TORQUE    = 14'h21ed;
    localparam logic [13:0] IDX_DONE_MODE = 14'h21ee;
    localparam logic [13:0] IDX_CHANGE    = 14'h21ef;
    localparam logic [13:0] IDX_OFFSET    = 14'h21f0;
    localparam logic [13:0] IDX_SEQ_CTRL  = 14'h21f4;
    localparam logic [13:0] IDX_SEQ_INDEX = 14'h21f5;

    // reset values
    localparam logic [15:0] RST_ACCEL     = 16'h0000;
    localparam logic [15:0] RST_TORQUE    = 16'h0000;
    localparam logic [15:0] RST_DONE_MODE = 16'h0000;
    localparam logic [15:0] RST_CHANGE    = 16'h0000;
    localparam logic [31:0] RST_OFFSET    = 32'h0000_0000;
    localparam logic [15:0] RST_SEQ_CTRL  = 16'h0000;

    // sequence control fields
    localparam int unsigned SEQ_DELAY_BIT  = 0;
    localparam int unsigned SEQ_SCALE_LSB  = 2;
    localparam int unsigned SEQ_REPEAT_BIT = 4;
    localparam logic [1:0]  SCALE_MS       = 2'h0;
    localparam logic [1:0]  SCALE_S        = 2'h1;
    localparam logic [1:0]  SCALE_MIN      = 2'h2;

    // acceleration register holds positions/s^2 divided by 256
    localparam logic [7:0]  ACCEL_FRAC     = 8'h00;
    localparam logic [15:0] TORQUE_FREE    = 16'hffff;
    localparam logic [3:0]  SEQ_IDX_FIRST  = 4'h0;
    localparam logic [3:0]  SEQ_IDX_STEP   = 4'h1;
    localparam logic [15:0] TIME_ZERO      = 16'h0000;
    localparam logic [15:0] TIME_ONE       = 16'h0001;

    typedef enum logic [0:0] {HOME_IDLE, HOME_SEEK} hsc_home_state_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ENTER, SEQ_WAIT_POS, SEQ_TIMING} hsc_seq_state_t;

endpackage

//--- logic/hsc_entry_timer.sv
`timescale 1ns/10ps
module hsc_entry_timer #(
    parameter int unsigned CYC_PER_MS = hsc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // control
    input  wire logic        i_load,
    input  wire logic        i_abort,
    input  wire logic [15:0] i_value,
    input  wire logic [1:0]  i_scale,
    // status
    output logic             o_expired,
    output logic             o_busy
);

    logic [31:0] pre_ff,    nxt_pre;
    logic [9:0]  ms_ff,     nxt_ms;
    logic [5:0]  sec_ff,    nxt_sec;
    logic [15:0] remain_ff, nxt_remain;
    logic        busy_ff,   nxt_busy;
    logic        exp_ff,    nxt_exp;
    logic        ms_tick;
    logic        s_tick;
    logic        min_tick;
    logic        unit_tick;

    always_comb begin
        ms_tick  = busy_ff && (pre_ff == 32'(CYC_PER_MS - 1));
        s_tick   = ms_tick && (ms_ff == 10'(hsc_pkg::MS_PER_S - 1));
        min_tick = s_tick && (sec_ff == 6'(hsc_pkg::S_PER_MIN - 1));
        // both scale bits set is undefined; it falls back to milliseconds
        unique case (i_scale)
            hsc_pkg::SCALE_S:   unit_tick = s_tick;
            hsc_pkg::SCALE_MIN: unit_tick = min_tick;
            default:            unit_tick = ms_tick;
        endcase
        nxt_pre    = ms_tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
        nxt_ms     = s_tick ? 10'h000 : (ms_tick ? ms_ff + 10'h001 : ms_ff);
        nxt_sec    = min_tick ? 6'h00 : (s_tick ? sec_ff + 6'h01 : sec_ff);
        nxt_remain = remain_ff;
        nxt_busy   = busy_ff;
        nxt_exp    = 1'b0;
        if (i_abort) begin
            nxt_busy = 1'b0;
        end else if (i_load) begin
            // prescalers restart so the first unit is a full one
            nxt_pre    = 32'h0000_0000;
            nxt_ms     = 10'h000;
            nxt_sec    = 6'h00;
            nxt_remain = i_value;
            nxt_busy   = (i_value != hsc_pkg::TIME_ZERO);
            nxt_exp    = (i_value == hsc_pkg::TIME_ZERO);
        end else if (unit_tick) begin
            nxt_remain = remain_ff - hsc_pkg::TIME_ONE;
            if (remain_ff == hsc_pkg::TIME_ONE) begin
                nxt_busy = 1'b0;
                nxt_exp  = 1'b1;
            end
        end
        if (!nxt_busy) begin
            nxt_pre = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pre_ff    <= 32'h0000_0000;
            ms_ff     <= 10'h000;
            sec_ff    <= 6'h00;
            remain_ff <= hsc_pkg::TIME_ZERO;
            busy_ff   <= 1'b0;
            exp_ff    <= 1'b0;
        end else begin
            pre_ff    <= nxt_pre;
            ms_ff     <= nxt_ms;
            sec_ff    <= nxt_sec;
            remain_ff <= nxt_remain;
            busy_ff   <= nxt_busy;
            exp_ff    <= nxt_exp;
        end
    end

    assign o_expired = exp_ff;
    assign o_busy    = busy_ff;

    a_minute_unit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (busy_ff && !i_load && !i_abort && i_scale == hsc_pkg::SCALE_MIN
         && min_tick)
        |=> (remain_ff == $past(remain_ff) - hsc_pkg::TIME_ONE) && (sec_ff == 6'h00))
        else $error("minute scale did not count down on a minute tick");

endmodule

//--- logic/hsc_top.sv
`timescale 1ns/10ps
module hsc_top #(
    parameter int unsigned CYC_PER_MS = hsc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hwdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // homing interface to the drive
    input  wire logic        i_home_start,
    input  wire logic        i_home_hard_stop,
    input  wire logic        i_home_point,
    input  wire logic [15:0] i_meas_torque,
    input  wire logic [31:0] i_motor_pos,
    output logic             o_homing_active,
    output logic [23:0]      o_accel_ref,
    output logic [15:0]      o_torque_limit,
    output logic             o_pos_load,
    output logic [31:0]      o_pos_load_value,
    output logic             o_mode_load,
    output logic [15:0]      o_mode_value,
    // sequence interface to the drive
    input  wire logic        i_seq_start,
    input  wire logic        i_seq_stop,
    input  wire logic        i_pos_reached,
    input  wire logic [15:0] i_entry_time,
    output logic [3:0]       o_sequence_entry_index,
    output logic             o_seq_active,
    output logic             o_entry_advance,
    output logic             o_seq_done
);

    // bus state
    logic        wr_pend_ff,  nxt_wr_pend;
    logic [13:0] wr_idx_ff,   nxt_wr_idx;
    logic [31:0] rdata_ff,    nxt_rdata;
    logic        addr_hit;
    logic        addr_take;

    // software registers
    logic [15:0] accel_ff,    nxt_accel;
    logic [15:0] torque_ff,   nxt_torque;
    logic [15:0] done_mode_ff, nxt_done_mode;
    logic [31:0] offset_ff,   nxt_offset;
    logic [15:0] seq_ctrl_ff, nxt_seq_ctrl;

    // homing state
    hsc_pkg::hsc_home_state_t home_ff, nxt_home;
    logic [15:0] change_ff,   nxt_change;
    logic [23:0] accel_ref_ff, nxt_accel_ref;
    logic [15:0] tq_lim_ff,   nxt_tq_lim;
    logic        pos_load_ff, nxt_pos_load;
    logic [31:0] pos_val_ff,  nxt_pos_val;
    logic        mode_ld_ff,  nxt_mode_ld;
    logic [15:0] mode_val_ff, nxt_mode_val;
    logic        home_hit;
    logic [31:0] pos_diff;

    // sequence state
    hsc_pkg::hsc_seq_state_t seq_ff, nxt_seq;
    logic [3:0]  idx_ff,      nxt_idx;
    logic        adv_ff,      nxt_adv;
    logic        done_ff,     nxt_done;
    logic        tmr_load;
    logic        tmr_abort;
    logic        tmr_expired;
    logic        tmr_busy;
    logic        delay_mode;
    logic        repeat_on;
    logic [1:0]  time_scale;

    always_comb begin
        delay_mode = seq_ctrl_ff[hsc_pkg::SEQ_DELAY_BIT];
        repeat_on  = seq_ctrl_ff[hsc_pkg::SEQ_REPEAT_BIT];
        time_scale = seq_ctrl_ff[hsc_pkg::SEQ_SCALE_LSB +: 2];
        pos_diff   = offset_ff - i_motor_pos;
    end

    // ---------------- bus slave ----------------
    // read data is sampled in the address phase so hrdata comes from a flop;
    // a read right behind a write to the same word sees the old value
    always_comb begin
        addr_hit    = (i_haddr[31:16] == 16'h0000);
        addr_take   = i_hsel && i_hready && i_htrans[1];
        nxt_wr_pend = addr_take && i_hwrite && addr_hit;
        nxt_wr_idx  = i_haddr[15:2];
        nxt_rdata   = 32'h0000_0000;
        if (addr_take && !i_hwrite && addr_hit) begin
            unique case (i_haddr[15:2])
                hsc_pkg::IDX_ACCEL:     nxt_rdata = {16'h0000, accel_ff};
                hsc_pkg::IDX_TORQUE:    nxt_rdata = {16'h0000, torque_ff};
                hsc_pkg::IDX_DONE_MODE: nxt_rdata = {16'h0000, done_mode_ff};
                hsc_pkg::IDX_CHANGE:    nxt_rdata = {16'h0000, change_ff};
                hsc_pkg::IDX_OFFSET:    nxt_rdata = offset_ff;
                hsc_pkg::IDX_SEQ_CTRL:  nxt_rdata = {16'h0000, seq_ctrl_ff};
                hsc_pkg::IDX_SEQ_INDEX: nxt_rdata = {28'h000_0000, idx_ff};
                default:                nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        nxt_accel     = accel_ff;
        nxt_torque    = torque_ff;
        nxt_done_mode = done_mode_ff;
        nxt_offset    = offset_ff;
        nxt_seq_ctrl  = seq_ctrl_ff;
        if (wr_pend_ff) begin
            unique case (wr_idx_ff)
                hsc_pkg::IDX_ACCEL:     nxt_accel     = i_hwdata[15:0];
                hsc_pkg::IDX_TORQUE:    nxt_torque    = i_hwdata[15:0];
                hsc_pkg::IDX_DONE_MODE: nxt_done_mode = i_hwdata[15:0];
                hsc_pkg::IDX_OFFSET:    nxt_offset    = i_hwdata;
                hsc_pkg::IDX_SEQ_CTRL:  nxt_seq_ctrl  = i_hwdata[15:0];
                default:                nxt_accel     = accel_ff;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= 14'h0000;
            rdata_ff     <= 32'h0000_0000;
            accel_ff     <= hsc_pkg::RST_ACCEL;
            torque_ff    <= hsc_pkg::RST_TORQUE;
            done_mode_ff <= hsc_pkg::RST_DONE_MODE;
            offset_ff    <= hsc_pkg::RST_OFFSET;
            seq_ctrl_ff  <= hsc_pkg::RST_SEQ_CTRL;
        end else begin
            wr_pend_ff   <= nxt_wr_pend;
            wr_idx_ff    <= nxt_wr_idx;
            rdata_ff     <= nxt_rdata;
            accel_ff     <= nxt_accel;
            torque_ff    <= nxt_torque;
            done_mode_ff <= nxt_done_mode;
            offset_ff    <= nxt_offset;
            seq_ctrl_ff  <= nxt_seq_ctrl;
        end
    end

    // ---------------- homing ----------------
    always_comb begin
        home_hit      = (home_ff == hsc_pkg::HOME_SEEK)
                        && (i_home_hard_stop ? (i_meas_torque >= torque_ff)
                                             : i_home_point);
        nxt_home      = home_ff;
        nxt_change    = change_ff;
        nxt_pos_load  = 1'b0;
        nxt_pos_val   = pos_val_ff;
        nxt_mode_ld   = 1'b0;
        nxt_mode_val  = mode_val_ff;
        nxt_accel_ref = {accel_ff, hsc_pkg::ACCEL_FRAC};
        nxt_tq_lim    = hsc_pkg::TORQUE_FREE;
        unique case (home_ff)
            hsc_pkg::HOME_IDLE: begin
                if (i_home_start) begin
                    nxt_home = hsc_pkg::HOME_SEEK;
                end
            end
            hsc_pkg::HOME_SEEK: begin
                if (i_home_hard_stop) begin
                    nxt_tq_lim = torque_ff;
                end
                if (home_hit) begin
                    nxt_home     = hsc_pkg::HOME_IDLE;
                    nxt_pos_load = 1'b1;
                    nxt_pos_val  = offset_ff;
                    nxt_change   = pos_diff[15:0];
                    nxt_mode_ld  = 1'b1;
                    nxt_mode_val = done_mode_ff;
                    nxt_tq_lim   = hsc_pkg::TORQUE_FREE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            home_ff      <= hsc_pkg::HOME_IDLE;
            change_ff    <= hsc_pkg::RST_CHANGE;
            accel_ref_ff <= 24'h00_0000;
            tq_lim_ff    <= hsc_pkg::TORQUE_FREE;
            pos_load_ff  <= 1'b0;
            pos_val_ff   <= 32'h0000_0000;
            mode_ld_ff   <= 1'b0;
            mode_val_ff  <= 16'h0000;
        end else begin
            home_ff      <= nxt_home;
            change_ff    <= nxt_change;
            accel_ref_ff <= nxt_accel_ref;
            tq_lim_ff    <= nxt_tq_lim;
            pos_load_ff  <= nxt_pos_load;
            pos_val_ff   <= nxt_pos_val;
            mode_ld_ff   <= nxt_mode_ld;
            mode_val_ff  <= nxt_mode_val;
        end
    end

    // ---------------- sequence ----------------
    // the entry time comes from the table outside, addressed by the index
    // output, so each new entry is judged one cycle after the index moves
    always_comb begin
        nxt_seq   = seq_ff;
        nxt_idx   = idx_ff;
        nxt_adv   = 1'b0;
        nxt_done  = 1'b0;
        tmr_load  = 1'b0;
        tmr_abort = 1'b0;
        if (i_seq_stop) begin
            nxt_seq   = hsc_pkg::SEQ_IDLE;
            tmr_abort = 1'b1;
        end else begin
            unique case (seq_ff)
                hsc_pkg::SEQ_IDLE: begin
                    if (i_seq_start) begin
                        nxt_idx = hsc_pkg::SEQ_IDX_FIRST;
                        nxt_seq = hsc_pkg::SEQ_ENTER;
                    end
                end
                hsc_pkg::SEQ_ENTER: begin
                    if (i_entry_time == hsc_pkg::TIME_ZERO && !repeat_on) begin
                        nxt_seq  = hsc_pkg::SEQ_IDLE;
                        nxt_done = 1'b1;
                    end else if (delay_mode) begin
                        nxt_seq = hsc_pkg::SEQ_WAIT_POS;
                    end else begin
                        tmr_load = 1'b1;
                        nxt_seq  = hsc_pkg::SEQ_TIMING;
                    end
                end
                hsc_pkg::SEQ_WAIT_POS: begin
                    if (i_pos_reached) begin
                        tmr_load = 1'b1;
                        nxt_seq  = hsc_pkg::SEQ_TIMING;
                    end
                end
                hsc_pkg::SEQ_TIMING: begin
                    // target position is not checked here on purpose
                    if (tmr_expired) begin
                        nxt_idx = idx_ff + hsc_pkg::SEQ_IDX_STEP;
                        nxt_adv = 1'b1;
                        nxt_seq = hsc_pkg::SEQ_ENTER;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            seq_ff  <= hsc_pkg::SEQ_IDLE;
            idx_ff  <= hsc_pkg::SEQ_IDX_FIRST;
            adv_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            seq_ff  <= nxt_seq;
            idx_ff  <= nxt_idx;
            adv_ff  <= nxt_adv;
            done_ff <= nxt_done;
        end
    end

    hsc_entry_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_load     (tmr_load),
        .i_abort    (tmr_abort),
        .i_value    (i_entry_time),
        .i_scale    (time_scale),
        .o_expired  (tmr_expired),
        .o_busy     (tmr_busy)
    );

    // ---------------- outputs ----------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    assign o_hrdata               = rdata_ff;
    assign o_homing_active        = (home_ff == hsc_pkg::HOME_SEEK);
    assign o_accel_ref            = accel_ref_ff;
    assign o_torque_limit         = tq_lim_ff;
    assign o_pos_load             = pos_load_ff;
    assign o_pos_load_value       = pos_val_ff;
    assign o_mode_load            = mode_ld_ff;
    assign o_mode_value           = mode_val_ff;
    assign o_sequence_entry_index = idx_ff;
    assign o_seq_active           = (seq_ff != hsc_pkg::SEQ_IDLE);
    assign o_entry_advance        = adv_ff;
    assign o_seq_done             = done_ff;

    // ---------------- checks ----------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_home_hit;
        home_ff == hsc_pkg::HOME_SEEK && home_hit;
    endsequence

    sequence s_zero_entry;
        seq_ff == hsc_pkg::SEQ_ENTER && !i_seq_stop && i_entry_time == hsc_pkg::TIME_ZERO;
    endsequence

    a_accel_scaling: assert property ($stable(accel_ff) [*2]
        |-> o_accel_ref == {accel_ff, hsc_pkg::ACCEL_FRAC})
        else $error("acceleration output not register times 256");
    a_torque_cap: assert property ((home_ff == hsc_pkg::HOME_SEEK) && i_home_hard_stop
        && !home_hit |=> o_torque_limit == $past(torque_ff))
        else $error("torque not capped during hard-stop homing");
    a_done_mode: assert property (s_home_hit |=> o_mode_load
        && o_mode_value == $past(done_mode_ff) ##1 !o_mode_load)
        else $error("done mode not applied after homing");
    a_change_kept: assert property (s_home_hit |=> change_ff == $past(pos_diff[15:0]))
        else $error("position change not recorded");
    a_offset_load: assert property (s_home_hit |=> o_pos_load
        && o_pos_load_value == $past(offset_ff) && !o_homing_active)
        else $error("offset not loaded at homing point");
    a_start_at_once: assert property (seq_ff == hsc_pkg::SEQ_ENTER && !i_seq_stop
        && !delay_mode && i_entry_time != hsc_pkg::TIME_ZERO
        |=> tmr_busy && seq_ff == hsc_pkg::SEQ_TIMING)
        else $error("timer did not start at once");
    a_wait_reached: assert property (seq_ff == hsc_pkg::SEQ_WAIT_POS |-> !tmr_busy)
        else $error("timer running before position reached");
    a_zero_end: assert property (s_zero_entry ##0 !repeat_on
        |=> seq_ff == hsc_pkg::SEQ_IDLE && o_seq_done)
        else $error("sequence did not end on zero time");
    a_zero_repeat: assert property (s_zero_entry ##0 repeat_on && !delay_mode
        |=> seq_ff == hsc_pkg::SEQ_TIMING && tmr_expired ##1 (o_entry_advance || $past(i_seq_stop)))
        else $error("repeat sequence stopped on zero time");
    a_index_step: assert property (seq_ff == hsc_pkg::SEQ_TIMING && tmr_expired
        && !i_seq_stop |=> o_sequence_entry_index == $past(idx_ff) + hsc_pkg::SEQ_IDX_STEP
        && o_entry_advance)
        else $error("entry index did not step");
    a_hard_hit: assert property (home_ff == hsc_pkg::HOME_SEEK && i_home_hard_stop
        && i_meas_torque >= torque_ff |=> o_pos_load)
        else $error("hard stop not taken as homing point");

endmodule

//--- sim/tb_homing_sequence_control.sv
`timescale 1ns/10ps
module tb_homing_sequence_control;
    localparam int unsigned CPM = 1;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [13:0] IXS [8] = '{hsc_pkg::IDX_ACCEL, hsc_pkg::IDX_TORQUE,
        hsc_pkg::IDX_DONE_MODE, hsc_pkg::IDX_OFFSET, hsc_pkg::IDX_SEQ_CTRL,
        hsc_pkg::IDX_CHANGE, hsc_pkg::IDX_SEQ_INDEX, 14'h21f1};
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0, hrdy, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, mpos = '0, pval;
    logic        hstart = 1'b0, hard = 1'b0, hpoint = 1'b0, act, pload, mload;
    logic [15:0] torq = '0, tlim, mval, etime = '0;
    logic [23:0] aref;
    logic        sstart = 1'b0, sstop = 1'b0, preach = 1'b0, sact, adv, sdone;
    logic [3:0]  idx;
    logic [31:0] seed = 32'h0000_9d5b;
    int          n_errors = 0, n_tests = 0, cycles = 0;

    hsc_top #(.CYC_PER_MS(CPM)) dut (
        .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwr), .i_hsize(hsize), .i_hready(hrdy), .i_hwdata(hwdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_home_start(hstart), .i_home_hard_stop(hard), .i_home_point(hpoint),
        .i_meas_torque(torq), .i_motor_pos(mpos), .o_homing_active(act),
        .o_accel_ref(aref), .o_torque_limit(tlim), .o_pos_load(pload),
        .o_pos_load_value(pval), .o_mode_load(mload), .o_mode_value(mval),
        .i_seq_start(sstart), .i_seq_stop(sstop), .i_pos_reached(preach),
        .i_entry_time(etime), .o_sequence_entry_index(idx), .o_seq_active(sact),
        .o_entry_advance(adv), .o_seq_done(sdone)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int unit_cyc(input logic [1:0] sc);
        return sc == 2'h1 ? CPM * hsc_pkg::MS_PER_S : CPM;
    endfunction

    function automatic logic [31:0] exp_change(input logic [31:0] o, input logic [31:0] p);
        return {16'h0000, o[15:0] - p[15:0]};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // zero wait states expected, but the master still waits on hready
    task automatic bus(input logic w, input logic [13:0] ix, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwr <= w;
        haddr <= {16'h0000, ix, 2'b00};
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
        chk({30'h0, hrdy, hresp}, 32'h0000_0002, "bus response");
    endtask

    task automatic wait_sig(input int which, input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge clk);
            if ((which == 0 && pload === 1'b1) || (which == 1 && adv === 1'b1) ||
                (which == 2 && sdone === 1'b1)) return;
        end
    endtask

    task automatic seq_go(input logic [15:0] ctrl, input logic [15:0] tv);
        logic [31:0] q;
        bus(1'b1, hsc_pkg::IDX_SEQ_CTRL, {16'h0000, ctrl}, q);
        etime <= tv;
        sstart <= 1'b1;
        @(posedge clk);
        sstart <= 1'b0;
    endtask

    task automatic seq_stop();
        sstop <= 1'b1;
        @(posedge clk);
        sstop <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, sact}, '0, "stopped");
    endtask

    // longest path is the one-minute entry, about 61k cycles in all
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] q;
        logic [31:0] v [5];
        int          n;
        int          u;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        chk({16'h0000, tlim}, 32'h0000_ffff, "free torque");
        foreach (IXS[i]) begin
            bus(1'b0, IXS[i], '0, q);
            chk(q, '0, "reset value");
        end
        foreach (v[i]) begin
            v[i] = rnd() | ONE;
            bus(1'b1, IXS[i], v[i], q);
            bus(1'b0, IXS[i], '0, q);
            chk(q, i == 3 ? v[i] : v[i] & 32'h0000_ffff, "rw reg");
        end
        for (int i = 5; i < 8; i++) begin
            bus(1'b1, IXS[i], rnd(), q);
            bus(1'b0, IXS[i], '0, q);
            chk(q, '0, "ro or unmapped");
        end
        chk({8'h00, aref}, {8'h00, v[0][15:0], 8'h00}, "accel");
        // hard-stop homing: torque one below the limit must not hit
        mpos <= rnd();
        hard <= 1'b1;
        torq <= v[1][15:0] - 16'h0001;
        hstart <= 1'b1;
        @(posedge clk);
        hstart <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, act}, ONE, "seeking");
        chk({16'h0000, tlim}, v[1] & 32'h0000_ffff, "torque cap");
        torq <= v[1][15:0];
        wait_sig(0, 5, n);
        chk({31'h0, mload}, ONE, "mode load");
        chk({16'h0000, mval}, v[2] & 32'h0000_ffff, "mode value");
        chk(pval, v[3], "offset load");
        bus(1'b0, hsc_pkg::IDX_CHANGE, '0, q);
        chk(q, exp_change(v[3], mpos), "change");
        // switch homing ignores torque
        hard <= 1'b0;
        torq <= 16'hffff;
        hstart <= 1'b1;
        @(posedge clk);
        hstart <= 1'b0;
        repeat (4) @(posedge clk);
        chk({16'h0000, tlim}, {31'h0, act} * 32'h0000_ffff, "switch seek");
        hpoint <= 1'b1;
        wait_sig(0, 5, n);
        chk(32'(n <= 5), ONE, "switch hit");
        hpoint <= 1'b0;
        for (int sc = 0; sc < 2; sc++) begin
            u = sc == 0 ? (rnd() % 8) + 1 : 1;
            seq_go({12'h000, sc[1:0], 2'b00}, u[15:0]);
            u = u * unit_cyc(sc[1:0]);
            wait_sig(1, u + 8, n);
            chk(32'(n >= u && n <= u + 6), ONE, "entry time");
            chk({28'h000_0000, idx}, ONE, "index step");
            seq_stop();
        end
        seq_go(16'h0008, 16'h0001);
        u = hsc_pkg::S_PER_MIN * unit_cyc(2'h1);
        wait_sig(1, u + 8, n);
        chk(32'(n >= u && n <= u + 6), ONE, "minutes");
        seq_stop();
        seq_go(16'h0001, 16'h0001);
        wait_sig(1, 20, n);
        chk(32'(n > 20), ONE, "wait pos");
        preach <= 1'b1;
        wait_sig(1, CPM + 8, n);
        chk(32'(n >= CPM && n <= CPM + 6), ONE, "after pos");
        seq_stop();
        preach <= 1'b0;
        seq_go('0, '0);
        wait_sig(2, 5, n);
        chk({31'h0, sdone}, ONE, "end on zero");
        repeat (2) @(posedge clk);
        chk({31'h0, sact}, '0, "ended");
        seq_go(16'h0010, '0);
        for (int k = 1; k <= 17; k++) begin
            wait_sig(1, 5, n);
            chk({28'h000_0000, idx}, 32'(k % 16), "wrap");
        end
        seq_stop();
        tally_and_finish();
    end
endmodule
